/* core/xfer_dec_cfg.svh */
// constants for the transfer instruction decoder
// assumes inclusion by the decoder package and module only
`ifndef XFER_DEC_CFG_SVH
`define XFER_DEC_CFG_SVH
`define IW_W        16
`define FMT_BIT     15
`define SRC_LSB     0
`define SRC_MSB     7
`define DST_LSB     8
`define DST_MSB     14
`define MOD_W       4
`define SRC_IDX_W   4
`define DST_SUB_W   3
`define PFX_W       5
`define DST_IDX_W   8
`define ACC_N       16
`define STK_N       16
`define DP_N        3
`define SP_W        4
`define SP_RST      4'hF
`define PFX_MOD     4'hB
`define PFX_SUB     3'h0
`define SP_MOD      4'hD
`define SP_SUB      3'h1
`endif

/* core/xfer_dec_pkg.sv */
// types for the transfer instruction decoder
// assumes the cfg header is on the include path
`include "xfer_dec_cfg.svh"
package xfer_dec_pkg;
  typedef struct packed {
    logic                  is_imm;
    logic [`SRC_MSB:0]     imm;
    logic [`MOD_W-1:0]     src_mod;
    logic [`SRC_IDX_W-1:0] src_idx;
    logic [`MOD_W-1:0]     dst_mod;
    logic [`DST_IDX_W-1:0] dst_idx;
  } xfer_dec_t;
  typedef enum logic [1:0] {STK_NONE, STK_PUSH, STK_POP} stk_op_t;
  typedef enum logic [1:0] {DP_HOLD, DP_INC, DP_DEC} dp_step_t;
endpackage

/* core/transfer_instruction_decoder.sv */
// transfer instruction decoder with prefix, stack pointer and data pointers
// assumes program memory presents one word per cycle and peripherals
// act on the decoded move in the same cycle; push and pop are never
// raised together by the caller, and a prefix word is always followed
// by the move that it extends; stack words come in on the accumulator
// write data bus
//
// Contract
// - only fixed 16-bit instruction words accepted
// - bit 15 picks literal or register source
// - bits 0..7 form the source operand
// - source low nibble module, high nibble index
// - bits 8..14 give destination module and subindex
// - upper 248 destinations need prefix bits
// - prefix write costs exactly one cycle
// - fetch and execute in one cycle
// - sixteen accumulators and sixteen-deep stack
// - three auto-stepping data pointers
// - register moves trigger side-effect operations
// - stack pointer resets 0Fh, push pre-increments
`timescale 1ns/1ps
`default_nettype none
`include "xfer_dec_cfg.svh"
module transfer_instruction_decoder
  import xfer_dec_pkg::*;
#(
  parameter int ACC_NUM = `ACC_N,
  parameter int STK_NUM = `STK_N,
  parameter int DP_NUM  = `DP_N
)(
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_in,
  input  wire logic [`IW_W-1:0]       instr_in,
  input  wire logic                   instr_valid_in,
  input  wire logic                   stk_push_in,
  input  wire logic                   stk_pop_in,
  input  wire dp_step_t [DP_NUM-1:0]  dp_step_in,
  input  wire logic [`IW_W-1:0]       acc_wdata_in,
  output var  xfer_dec_t              dec_out,
  output logic                        dec_valid_out,
  output logic                        side_effect_out,
  output logic [`SP_W-1:0]            stack_pointer_out,
  output logic [`PFX_W-1:0]           pfx_out,
  output logic [DP_NUM-1:0][`IW_W-1:0] dp_out,
  output logic [`IW_W-1:0]            acc_sel_out,
  output logic [`IW_W-1:0]            stk_top_out
);
  // =========================================================
  // decode
  // =========================================================
  logic [`PFX_W-1:0]           destination_prefix_register_r;
  logic [`PFX_W-1:0]           destination_prefix_register_nxt;
  logic [`SP_W-1:0]            stack_pointer_r;
  logic [`SP_W-1:0]            stack_pointer_nxt;
  logic [DP_NUM-1:0][`IW_W-1:0] dp_r;
  logic [DP_NUM-1:0][`IW_W-1:0] dp_nxt;
  logic [ACC_NUM-1:0][`IW_W-1:0] acc_r;
  logic [ACC_NUM-1:0][`IW_W-1:0] acc_nxt;
  xfer_dec_t                   dec_nxt;
  xfer_dec_t                   dec_r;
  logic                        valid_r;
  logic                        pfx_wr;
  logic                        se_r;
  // control strobes decoded from the current word
  logic                        valid_nxt;
  logic                        sp_load;
  logic [`DST_SUB_W-1:0]       dst_sub;
  // return stack storage and its push slot
  logic [`SP_W-1:0]            stk_wr_ptr;
  logic [STK_NUM-1:0][`IW_W-1:0] stk_r;
  logic [STK_NUM-1:0][`IW_W-1:0] stk_nxt;

  // =========================================================
  // field decode
  // =========================================================
  // word layout: [15] format, [14:12] destination subindex,
  // [11:8] destination module, [7:4] source index, [3:0] source module
  assign dst_sub = instr_in[`DST_MSB:`DST_LSB+`MOD_W];

  // field split; all in the fetch cycle, no pipeline
  always_comb
  begin
    dec_nxt         = '0;
    dec_nxt.is_imm  = ~instr_in[`FMT_BIT];
    dec_nxt.imm     = instr_in[`SRC_MSB:`SRC_LSB];
    dec_nxt.src_mod = instr_in[`SRC_LSB+`MOD_W-1:`SRC_LSB];
    dec_nxt.src_idx = instr_in[`SRC_MSB:`SRC_LSB+`MOD_W];
    dec_nxt.dst_mod = instr_in[`DST_LSB+`MOD_W-1:`DST_LSB];
    // prefix bits stack above the three-bit subindex
    dec_nxt.dst_idx = {destination_prefix_register_r,
                       dst_sub};
  end

  // a prefix load is itself a move, hence its single extra cycle
  assign pfx_wr = instr_valid_in &&
                  dec_nxt.dst_mod == `PFX_MOD &&
                  dst_sub == `PFX_SUB;

  // stack pointer load through its own register address
  assign sp_load = instr_valid_in && !pfx_wr &&
                   dec_nxt.dst_mod == `SP_MOD &&
                   dst_sub == `SP_SUB;

  // prefix loads are swallowed here; downstream sees no move for them
  assign valid_nxt = instr_valid_in && !pfx_wr;

  // =========================================================
  // prefix register
  // =========================================================
  always_comb
  begin
    destination_prefix_register_nxt = destination_prefix_register_r;
    if (pfx_wr)
      destination_prefix_register_nxt =
        instr_in[`SRC_LSB+`PFX_W-1:`SRC_LSB];
    else if (instr_valid_in)
      destination_prefix_register_nxt = '0;
  end

  // =========================================================
  // stack pointer and data pointers
  // =========================================================
  always_comb
  begin
    stack_pointer_nxt = stack_pointer_r;
    // push wins if both arrive; caller must not issue both
    if (stk_push_in)
      stack_pointer_nxt = stack_pointer_r + `SP_W'(1);
    else if (stk_pop_in)
      stack_pointer_nxt = stack_pointer_r - `SP_W'(1);
    // a direct load beats any push or pop in the same cycle
    if (sp_load)
      stack_pointer_nxt = instr_in[`SP_W-1:0];
  end

  genvar g;
  generate
    for (g = 0; g < DP_NUM; g++)
    begin : g_dp
      // step after the access, no extra instruction needed
      // pointers wrap silently at either end of the word range
      always_comb
      begin
        dp_nxt[g] = dp_r[g];
        unique case (dp_step_in[g])
          DP_INC:  dp_nxt[g] = dp_r[g] + `IW_W'(1);
          DP_DEC:  dp_nxt[g] = dp_r[g] - `IW_W'(1);
          DP_HOLD: dp_nxt[g] = dp_r[g];
          default: dp_nxt[g] = dp_r[g];
        endcase
      end
    end
  endgenerate

  // =========================================================
  // return stack
  // =========================================================
  // push stores at the pre-incremented slot; a pop only moves the
  // pointer, since the word on top already shows on stk_top_out
  assign stk_wr_ptr = stack_pointer_r + `SP_W'(1);

  // no overflow guard: a push past the last slot wraps onto the oldest
  always_comb
  begin
    stk_nxt = stk_r;
    if (stk_push_in)
      stk_nxt[stk_wr_ptr] = acc_wdata_in;
  end

  // =========================================================
  // accumulators
  // =========================================================
  // accumulator file, written by a move into module 0, index 0..F
  // only index bits [3:0] reach the file; higher prefix bits alias
  always_comb
  begin
    acc_nxt = acc_r;
    if (instr_valid_in && !pfx_wr && dec_nxt.dst_mod == '0)
      acc_nxt[dec_nxt.dst_idx[`SP_W-1:0]] = acc_wdata_in;
  end

  // =========================================================
  // registers
  // =========================================================
  // every register loads on every edge; no enables anywhere
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      destination_prefix_register_r <= '0;
      stack_pointer_r <= `SP_RST;
      dp_r    <= '0;
      acc_r   <= '0;
      stk_r   <= '0;
      dec_r   <= '0;
      valid_r <= 1'b0;
      se_r    <= 1'b0;
    end
    else
    begin
      destination_prefix_register_r <= destination_prefix_register_nxt;
      stack_pointer_r <= stack_pointer_nxt;
      dp_r    <= dp_nxt;
      acc_r   <= acc_nxt;
      stk_r   <= stk_nxt;
      dec_r   <= dec_nxt;
      valid_r <= valid_nxt;
      se_r    <= valid_nxt;
    end
  end

  // outputs straight from flops; the read muxes add no storage
  assign dec_out           = dec_r;
  assign dec_valid_out     = valid_r;
  assign side_effect_out   = se_r;
  assign stack_pointer_out = stack_pointer_r;
  assign pfx_out           = destination_prefix_register_r;
  assign dp_out            = dp_r;
  assign acc_sel_out       = acc_r[dec_r.src_idx];
  assign stk_top_out       = stk_r[stack_pointer_r];
endmodule
`default_nettype wire

/* verif/xfer_dec_checker.sv */
// checker for the transfer instruction decoder
// assumes it is bound onto the decoder top module
`timescale 1ns/1ps
`default_nettype none
module xfer_dec_checker
  import xfer_dec_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic [15:0] instr_in,
  input wire logic        instr_valid_in,
  input wire logic        stk_push_in,
  input wire logic        stk_pop_in,
  input wire xfer_dec_t   dec_out,
  input wire logic        dec_valid_out,
  input wire logic [3:0]  stack_pointer_out,
  input wire logic [4:0]  pfx_out,
  input wire logic        side_effect_out,
  input wire logic [15:0] acc_wdata_in,
  input wire logic [15:0] stk_top_out
);
  // ==========
  // request classes: prefix load, plain move, stack pointer load
  logic pfx_w;
  logic mv_w;
  logic spw_w;
  assign pfx_w = instr_valid_in && instr_in[14:8] == 7'h0B;
  assign mv_w  = instr_valid_in && !pfx_w;
  assign spw_w = instr_valid_in && instr_in[14:8] == 7'h1D;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ==========
  // properties
  a_move_valid: assert property (mv_w |=> dec_valid_out)
    else $error("no valid after move");
  a_pfx_novalid: assert property (pfx_w |=> !dec_valid_out)
    else $error("valid after prefix");
  a_pfx_load: assert property (pfx_w |=> pfx_out == $past(instr_in[4:0]))
    else $error("prefix not loaded");
  a_pfx_clear: assert property (mv_w |=> pfx_out == 5'h00)
    else $error("prefix not cleared");
  a_dst_index: assert property (mv_w |=> dec_out.dst_idx ==
    {$past(pfx_out), $past(instr_in[14:12])} && dec_out.dst_mod ==
    $past(instr_in[11:8])) else $error("bad destination");
  a_src_field: assert property (mv_w |=> dec_out.imm ==
    $past(instr_in[7:0]) && dec_out.is_imm == !$past(instr_in[15]))
    else $error("bad source field");
  a_src_select: assert property (mv_w |=> {dec_out.src_idx,
    dec_out.src_mod} == $past(instr_in[7:0])) else $error("bad source reg");
  a_sp_push: assert property (stk_push_in && !spw_w |=>
    stack_pointer_out == $past(stack_pointer_out) + 4'h1)
    else $error("push step wrong");
  a_sp_pop: assert property (stk_pop_in && !stk_push_in && !spw_w |=>
    stack_pointer_out == $past(stack_pointer_out) - 4'h1)
    else $error("pop step wrong");
  a_side_effect: assert property (mv_w |=> side_effect_out)
    else $error("no side effect after move");
  a_sp_load: assert property (spw_w |=>
    stack_pointer_out == $past(instr_in[3:0])) else $error("sp load wrong");
  a_stk_push: assert property (stk_push_in && !spw_w |=>
    stk_top_out == $past(acc_wdata_in)) else $error("push word lost");
endmodule
bind transfer_instruction_decoder xfer_dec_checker xfer_dec_checker_inst (
  .sys_clk_in, .rst_in, .instr_in, .instr_valid_in, .stk_push_in,
  .stk_pop_in, .dec_out, .dec_valid_out, .stack_pointer_out, .pfx_out,
  .side_effect_out, .acc_wdata_in, .stk_top_out);
`default_nettype wire

/* verif/prog_mem_model.sv */
// program memory model: one random word per cycle, some idle cycles
// assumes words are taken at the rising edge after they change
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  input  wire logic        sys_clk_in,
  output logic [15:0] instr_out = 16'h0000,
  output logic        valid_out = 1'b0
);
  // ==========
  // word source; stack pointer loads left in, prefixes made common
  integer      seed = 13639;
  logic [15:0] w;
  always @(negedge sys_clk_in)
  begin
    w = $random(seed);
    if (w[7:5] == 3'h0) w[14:8] = 7'h0B;
    instr_out <= w;
    valid_out <= w[3] | w[4];
  end
endmodule
`default_nettype wire

/* verif/transfer_instruction_decoder_test.sv */
// self-checking bench for the transfer instruction decoder
// assumes the package and the program memory model are compiled first
`timescale 1ns/1ps
`default_nettype none
module transfer_instruction_decoder_test;
  import xfer_dec_pkg::*;
  logic sys_clk_in = 1'b0, rst_in = 1'b1, instr_valid_in;
  logic stk_push_in = 1'b0, stk_pop_in = 1'b0, dec_valid_out, m_vld;
  logic side_effect_out;
  logic [15:0] instr_in, acc_wdata_in = 16'h0000, acc_sel_out, stk_top_out;
  logic [15:0] m_acc [16], m_stk [16];
  dp_step_t [2:0] dp_step_in = {DP_HOLD, DP_HOLD, DP_HOLD};
  xfer_dec_t dec_out, m_dec;
  logic [3:0] stack_pointer_out, m_sp, m_si;
  logic [4:0] pfx_out, m_pfx;
  logic [2:0][15:0] dp_out, m_dp;
  logic [31:0] r;
  integer seed = 13639, error_cnt = 0, num_checks = 0, i;
  transfer_instruction_decoder transfer_instruction_decoder_inst (
    .sys_clk_in, .rst_in, .instr_in, .instr_valid_in, .stk_push_in,
    .stk_pop_in, .dp_step_in, .acc_wdata_in, .dec_out, .dec_valid_out,
    .side_effect_out, .stack_pointer_out, .pfx_out, .dp_out, .acc_sel_out,
    .stk_top_out);
  prog_mem_model prog_mem_model_inst (.sys_clk_in,
    .instr_out(instr_in), .valid_out(instr_valid_in));
  task chk(input logic [47:0] got, input logic [47:0] exp);
  begin
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task complete_run;
  begin
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  // ==========
  // reference model, stepped on the same edge as the design
  always @(posedge sys_clk_in or posedge rst_in)
  if (rst_in)
  begin
    {m_pfx, m_vld, m_dp, m_si} = '0;
    m_sp = 4'hF;
    for (i = 0; i < 16; i++)
      {m_acc[i], m_stk[i]} = '0;
  end
  else
  begin
    m_vld = instr_valid_in && instr_in[14:8] != 7'h0B;
    if (m_vld)
      m_dec = {~instr_in[15], instr_in[7:0], instr_in[3:0], instr_in[7:4],
               instr_in[11:8], m_pfx, instr_in[14:12]};
    if (m_vld && instr_in[11:8] == 4'h0)
      m_acc[{m_pfx[0], instr_in[14:12]}] = acc_wdata_in;
    if (stk_push_in)
      m_stk[m_sp + 4'h1] = acc_wdata_in;
    m_si = instr_in[7:4];
    m_pfx = m_vld ? 5'h00 : instr_valid_in ? instr_in[4:0] : m_pfx;
    m_sp = stk_push_in ? m_sp + 4'h1 : stk_pop_in ? m_sp - 4'h1 : m_sp;
    if (m_vld && instr_in[14:8] == 7'h1D)
      m_sp = instr_in[3:0];
    for (i = 0; i < 3; i++)
      m_dp[i] = m_dp[i] + (dp_step_in[i] == DP_INC) - (dp_step_in[i] == DP_DEC);
  end
  // ==========
  // compare settled outputs, then drive new random side inputs
  always @(negedge sys_clk_in)
  begin
    if (!rst_in)
    begin
      chk(dec_valid_out, m_vld);
      if (m_vld) chk(dec_out, m_dec);
      chk(pfx_out, m_pfx);
      chk(stack_pointer_out, m_sp);
      chk(dp_out, m_dp);
      chk(side_effect_out, m_vld);
      chk(acc_sel_out, m_acc[m_si]);
      chk(stk_top_out, m_stk[m_sp]);
    end
    r = $random(seed);
    {stk_push_in, stk_pop_in, acc_wdata_in} <= r[31:14];
    for (i = 0; i < 3; i++)
      dp_step_in[i] <= r[2*i+1] ? DP_DEC : dp_step_t'({1'b0, r[2*i]});
  end
  always #4 sys_clk_in = ~sys_clk_in;
  initial
  begin
    repeat (3) @(posedge sys_clk_in);
    @(negedge sys_clk_in) rst_in <= 1'b0;
    repeat (2000) @(posedge sys_clk_in);
    complete_run;
  end
  // watchdog, well past the 2000-cycle run
  initial
  begin
    #40000;
    error_cnt++;
    complete_run;
  end
endmodule
`default_nettype wire
